// *** mpa_arbiter.sv ***
// Bus arbitration for one processor sharing an external bus with up to
// seven peers and a host. Pins arrive asynchronously and are synchronised.
// Summary of operation
// R1 - Drive own request line, watch others
// R2 - Identity selects line and priority order
// R3 - Identity changes only under reset
// R4 - Undriven request lines held high externally
// R5 - Master asserts debug master indicator
// R6 - Master and lock pins sampled as straps
// R7 - Lock output shows master holds lock
// R8 - Back-off makes processor abandon transaction
// R9 - Host asserts request to get bus
// R10 - Finish transaction, release, then grant host
// R11 - Float bus outputs when host granted
// R12 - SDRAM into self-refresh before host grant
// R13 - Hold grant until host drops request
// R14 - Only master drives grant; others monitor
// R15 - Core priority line while core accesses
// R16 - Core priority preempts background DMA
// R17 - DMA priority line while high DMA accesses
// R18 - DMA priority preempts normal DMA
// R19 - Priority lines are open-drain, shared
// R20 - Unused priority lines left unconnected
// R21 - After back-off, rerequest and restart transaction
`timescale 1ns/1ps

module mpa_arbiter
  import mpa_pkg::*;
(
  input  wire logic                           core_clk,
  input  wire logic                           reset_n,
  input  wire logic                           clk_en,
  input  wire logic [mpa_pkg::ID_W-1:0]       processor_identity,
  input  wire logic [mpa_pkg::NUM_PROC-1:0]   arb_request_lines_in,
  output logic      [mpa_pkg::NUM_PROC-1:0]   arb_request_lines_out,
  output logic      [mpa_pkg::NUM_PROC-1:0]   arb_request_lines_oe,
  input  wire logic                           master_indicator_in,
  output logic                                master_indicator_n,
  output logic                                master_indicator_oe,
  input  wire logic                           bus_locked_flag_in,
  output logic                                bus_locked_flag_n,
  output logic                                bus_locked_flag_oe,
  input  wire logic                           backoff_input_n,
  input  wire logic                           host_req_n,
  input  wire logic                           host_grant_in,
  output logic                                host_grant_n,
  output logic                                host_grant_oe,
  input  wire logic                           core_priority_line_in,
  output logic                                core_priority_line_out,
  output logic                                core_priority_line_oe,
  input  wire logic                           dma_priority_line_in,
  output logic                                dma_priority_line_out,
  output logic                                dma_priority_line_oe,
  input  wire mpa_pkg::mpa_local_t            local_req,
  output logic                                bus_outputs_oe,
  output logic                                sdram_self_refresh,
  output logic                                bus_granted,
  output logic                                preempt_bg_dma,
  output logic                                preempt_np_dma,
  output logic                                restart_xact,
  output mpa_pkg::mpa_strap_t                 straps
);
  import mpa_pkg::*;

  // Two-stage synchronisers; stage one is read only by stage two
  logic [NUM_PROC-1:0] req_s1_reg;
  logic [NUM_PROC-1:0] req_s2_reg;
  logic [5:0]          pin_s1_reg;
  logic [5:0]          pin_s2_reg;
  logic [ID_W-1:0]     id_s1_reg;
  logic [ID_W-1:0]     id_s2_reg;
  logic                master_s1_reg;     // Master indicator strap, first stage
  logic                master_s2_reg;     // Master indicator strap, second stage

  // Identity latched once after reset; held constant by the system
  logic [ID_W-1:0]     id_reg;
  logic                strap_done_reg;

  mpa_state_t          state_reg;
  mpa_state_t          state_next;
  logic [CNT_W-1:0]    cnt_reg;
  logic                aborted_reg;       // A back-off cut a transaction short

  // Synchronised views of the pins
  logic backoff_s;
  logic hreq_s;
  logic hgnt_s;
  logic core_prio_s;
  logic dma_prio_s;
  logic want_bus;
  logic higher_req;
  logic [NUM_PROC-1:0] own_line;

  assign backoff_s   = ~pin_s2_reg[0];
  assign hreq_s      = ~pin_s2_reg[1];
  assign hgnt_s      = ~pin_s2_reg[2];
  assign core_prio_s = ~pin_s2_reg[3];
  assign dma_prio_s  = ~pin_s2_reg[4];

  // One-hot mask for an identity: value 000 is line 0, 111 is line 7
  function automatic logic [NUM_PROC-1:0] id_line(input logic [ID_W-1:0] id);
    id_line = NUM_PROC'(1) << id; // R2
  endfunction

  // Any active request from a processor with a lower identity wins priority
  function automatic logic lower_id_active(input logic [NUM_PROC-1:0] lines,
                                           input logic [ID_W-1:0]     id);
    logic [NUM_PROC-1:0] below;
    below = id_line(id) - NUM_PROC'(1);
    lower_id_active = |(~lines & below); // R2
  endfunction

  assign own_line   = id_line(id_reg);
  assign want_bus   = local_req.core_req | local_req.hp_dma_req |
                      local_req.np_dma_req | local_req.bg_dma_req | aborted_reg;
  assign higher_req = lower_id_active(req_s2_reg, id_reg); // R1

  // Input synchronisers, kept out of reset on purpose: they follow the pins
  // while reset is held, so identity and straps are settled at release
  always_ff @(posedge core_clk)
  begin
    if (clk_en)
    begin
      req_s1_reg    <= arb_request_lines_in; // R1
      req_s2_reg    <= req_s1_reg;
      pin_s1_reg    <= {bus_locked_flag_in, dma_priority_line_in, core_priority_line_in,
                        host_grant_in, host_req_n, backoff_input_n};
      pin_s2_reg    <= pin_s1_reg;
      master_s1_reg <= master_indicator_in; // R6
      master_s2_reg <= master_s1_reg;
      id_s1_reg     <= processor_identity;
      id_s2_reg     <= id_s1_reg;
    end
  end

  // Straps and identity are caught once, after release, by a clocked process
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_done_reg <= 1'b0;
      id_reg         <= 3'h0;
      straps         <= '0;
    end
    else if (clk_en && !strap_done_reg)
    begin
      // Pins are floated in reset so the straps read their external level
      strap_done_reg      <= 1'b1;
      id_reg              <= id_s2_reg; // R3
      straps.lock_strap   <= pin_s2_reg[5]; // R6
      straps.master_strap <= master_s2_reg; // R6
    end
  end

  // Next-state selection
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      MPA_IDLE:
        if (strap_done_reg && want_bus && !hgnt_s && !backoff_s)
          state_next = MPA_REQ;
      MPA_REQ:
        // Wait until a peer that asked in the same cycle is visible
        if (hgnt_s || backoff_s)
          state_next = MPA_IDLE; // R14
        else if (cnt_reg == CNT_ZERO && !higher_req)
          state_next = MPA_OWN; // R1
      MPA_OWN:
        if (backoff_s)
          state_next = MPA_BACKOFF; // R8
        else if (hreq_s)
          state_next = MPA_DRAIN; // R10
        else if (!want_bus && !local_req.lock_req && !local_req.xact_busy)
          state_next = MPA_IDLE;
        else if (higher_req && !local_req.lock_req && !local_req.xact_busy &&
                 !local_req.core_req)
          state_next = MPA_IDLE;
      MPA_DRAIN:
        if (backoff_s)
          state_next = MPA_BACKOFF; // R8
        else if (!local_req.xact_busy)
          state_next = MPA_SREF; // R10
      MPA_SREF:
        if (cnt_reg == CNT_ZERO)
          state_next = MPA_HOST; // R12
      MPA_HOST:
        if (!hreq_s)
          state_next = MPA_IDLE; // R13
      MPA_BACKOFF:
        if (!backoff_s && !hreq_s)
          state_next = MPA_IDLE; // R21
      default:
        state_next = MPA_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= MPA_IDLE;
    else if (clk_en)
      state_reg <= state_next;
  end

  // Shared settle counter: synchroniser wait on a new request, then the
  // self-refresh wait on release; the two phases never overlap
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_reg <= CNT_ZERO;
    else if (clk_en)
    begin
      if (state_next == MPA_REQ && state_reg != MPA_REQ)
        cnt_reg <= SYNC_COUNT; // R1
      else if (state_next == MPA_SREF && state_reg != MPA_SREF)
        cnt_reg <= SR_COUNT - CNT_W'(1);
      else if (cnt_reg != CNT_ZERO)
        cnt_reg <= cnt_reg - CNT_W'(1);
    end
  end

  // Remember an aborted transaction so the bus is asked for again
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      aborted_reg <= 1'b0;
    else if (clk_en)
    begin
      if (state_next == MPA_BACKOFF && local_req.xact_busy)
        aborted_reg <= 1'b1; // R21
      else if (state_reg == MPA_OWN)
        aborted_reg <= 1'b0;
    end
  end

  // Pin drivers: every output straight from a flip-flop
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      arb_request_lines_out  <= '0;
      arb_request_lines_oe   <= '0;
      master_indicator_n     <= 1'b1;
      master_indicator_oe    <= 1'b0;
      bus_locked_flag_n      <= 1'b1;
      bus_locked_flag_oe     <= 1'b0;
      host_grant_n           <= 1'b1;
      host_grant_oe          <= 1'b0;
      core_priority_line_out <= 1'b0;
      core_priority_line_oe  <= 1'b0;
      dma_priority_line_out  <= 1'b0;
      dma_priority_line_oe   <= 1'b0;
      bus_outputs_oe         <= 1'b0;
      sdram_self_refresh     <= 1'b0;
      bus_granted            <= 1'b0;
      preempt_bg_dma         <= 1'b0;
      preempt_np_dma         <= 1'b0;
      restart_xact           <= 1'b0;
    end
    else if (clk_en && strap_done_reg)
    begin
      // Only the own line is ever enabled; low is the active level
      arb_request_lines_out <= '0;
      arb_request_lines_oe  <= (state_next == MPA_REQ || state_next == MPA_OWN ||
                                state_next == MPA_DRAIN) ? own_line : '0; // R1
      master_indicator_oe   <= 1'b1;
      master_indicator_n    <= !(state_next == MPA_OWN || state_next == MPA_DRAIN); // R5
      bus_locked_flag_oe    <= (state_next == MPA_OWN);
      bus_locked_flag_n     <= !(state_next == MPA_OWN && local_req.lock_req); // R7
      // Grant is driven only by the master side of the handover
      host_grant_oe         <= (state_next == MPA_HOST); // R14
      host_grant_n          <= !(state_next == MPA_HOST); // R13
      // Open-drain: drive low or release
      core_priority_line_out <= 1'b0;
      core_priority_line_oe  <= local_req.core_req; // R15 R19
      dma_priority_line_out  <= 1'b0;
      dma_priority_line_oe   <= local_req.hp_dma_req; // R17 R19
      bus_outputs_oe        <= (state_next == MPA_OWN || state_next == MPA_DRAIN); // R11
      sdram_self_refresh    <= (state_next == MPA_SREF || state_next == MPA_HOST); // R12
      bus_granted           <= (state_next == MPA_OWN);
      // A peer raising a priority line preempts the matching local DMA class
      preempt_bg_dma        <= (state_reg == MPA_OWN) && core_prio_s &&
                               !local_req.core_req; // R16
      preempt_np_dma        <= (state_reg == MPA_OWN) && dma_prio_s &&
                               !local_req.hp_dma_req; // R18
      restart_xact          <= aborted_reg && (state_next == MPA_OWN) &&
                               (state_reg != MPA_OWN); // R21
    end
  end

endmodule

// *** mpa_pkg.sv ***
// Package for the multiprocessor bus arbiter: constants, states and carriers.
// Assumes a single 20 MHz core clock; no software-visible registers.
package mpa_pkg;

  localparam int unsigned NUM_PROC      = 8;      // Request lines on the shared bus
  localparam int unsigned ID_W          = 3;      // Identity width
  localparam int unsigned CLK_PERIOD_NS = 50;     // Core clock period
  localparam int unsigned SR_ENTRY_NS   = 100;    // Least time for self-refresh entry
  localparam int unsigned SR_CYCLES     =
    (SR_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 4;      // Width of the settle counter
  localparam logic [CNT_W-1:0] SR_COUNT = CNT_W'(SR_CYCLES);
  // Edges a peer's request line takes through the synchroniser
  localparam logic [CNT_W-1:0] SYNC_COUNT = 4'h2;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [NUM_PROC-1:0] REQ_IDLE = 8'hFF; // All request lines released

  // Arbiter states, Gray coded along request, own, release, host
  typedef enum logic [2:0] {
    MPA_IDLE    = 3'b000,  // Not master, not requesting
    MPA_REQ     = 3'b001,  // Own request line asserted
    MPA_OWN     = 3'b011,  // Bus master
    MPA_DRAIN   = 3'b010,  // Finishing outstanding transaction
    MPA_SREF    = 3'b110,  // Placing SDRAM into self-refresh
    MPA_HOST    = 3'b111,  // Host granted
    MPA_BACKOFF = 3'b101   // Backed off; waiting to retry
  } mpa_state_t;

  // Local traffic requests from the core and DMA engines
  typedef struct packed {
    logic core_req;     // Core needs the external bus
    logic hp_dma_req;   // High-priority DMA needs the bus
    logic np_dma_req;   // Normal DMA needs the bus
    logic bg_dma_req;   // Background DMA needs the bus
    logic lock_req;     // Master wants the bus locked
    logic xact_busy;    // A transaction is outstanding
  } mpa_local_t;

  // Straps caught at reset release
  typedef struct packed {
    logic master_strap;
    logic lock_strap;
  } mpa_strap_t;

endpackage

// *** mpa_arbiter_props.sv ***
// Concurrent checks on the ports of the bus arbiter.
// Assumes one core clock domain and the async active-low reset.
`timescale 1ns/1ps

module mpa_arbiter_props
  import mpa_pkg::*;
(
  input wire logic                         core_clk,
  input wire logic                         reset_n,
  input wire logic [mpa_pkg::ID_W-1:0]     processor_identity,
  input wire logic [mpa_pkg::NUM_PROC-1:0] arb_request_lines_out,
  input wire logic [mpa_pkg::NUM_PROC-1:0] arb_request_lines_oe,
  input wire logic                         master_indicator_n,
  input wire logic                         bus_locked_flag_n,
  input wire logic                         bus_locked_flag_oe,
  input wire logic                         backoff_input_n,
  input wire logic                         host_req_n,
  input wire logic                         host_grant_oe,
  input wire logic                         core_priority_line_out,
  input wire logic                         core_priority_line_oe,
  input wire logic                         dma_priority_line_out,
  input wire logic                         dma_priority_line_oe,
  input wire mpa_pkg::mpa_local_t          local_req,
  input wire logic                         bus_outputs_oe,
  input wire logic                         sdram_self_refresh,
  input wire logic                         bus_granted,
  input wire logic                         restart_xact
);
  // All checks share the core clock and are quiet under reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  // Only the own line, chosen by identity, is ever pulled
  a_req_own_line: assert property (|arb_request_lines_oe |->
    arb_request_lines_oe == (8'h01 << processor_identity)) else $error("foreign request line");
  // Shared lines are only ever pulled low, never driven high
  a_open_drain: assert property (arb_request_lines_out == 8'h00 &&
    !core_priority_line_out && !dma_priority_line_out) else $error("line driven high");
  a_master_shown: assert property (bus_granted |-> !master_indicator_n)
    else $error("master indicator missing");
  a_lock_master: assert property (!bus_locked_flag_n |-> bus_granted && bus_locked_flag_oe)
    else $error("lock shown by non-master");
  a_backoff_drop: assert property (!backoff_input_n && bus_granted |-> ##[1:4] !bus_granted)
    else $error("bus kept under back-off");
  a_float_host: assert property (host_grant_oe |-> !bus_outputs_oe && !bus_granted)
    else $error("bus driven during host grant");
  a_sref_first: assert property ($rose(host_grant_oe) |-> $past(sdram_self_refresh))
    else $error("grant before self-refresh");
  a_grant_hold: assert property (host_grant_oe && !host_req_n |=> host_grant_oe)
    else $error("grant dropped early");
  a_cpa_core: assert property (core_priority_line_oe |-> $past(local_req.core_req))
    else $error("core priority without core access");
  a_dpa_dma: assert property (dma_priority_line_oe |-> $past(local_req.hp_dma_req))
    else $error("dma priority without high dma");
  a_restart_once: assert property (restart_xact |=> !restart_xact)
    else $error("restart longer than a cycle");
endmodule

bind mpa_arbiter mpa_arbiter_props u_props (.core_clk, .reset_n, .processor_identity,
  .arb_request_lines_out, .arb_request_lines_oe, .master_indicator_n, .bus_locked_flag_n,
  .bus_locked_flag_oe, .backoff_input_n, .host_req_n, .host_grant_oe,
  .core_priority_line_out, .core_priority_line_oe, .dma_priority_line_out,
  .dma_priority_line_oe, .local_req, .bus_outputs_oe, .sdram_self_refresh, .bus_granted,
  .restart_xact);

// *** mpa_peer_model.sv ***
// Peers and host wiring: resolves the shared open-drain lines.
// Assumes pull-ups on every line; the bench tells which peer pulls.
`timescale 1ns/1ps

module mpa_peer_model
  import mpa_pkg::*;
(
  input  wire logic [mpa_pkg::NUM_PROC-1:0] peer_pull,
  input  wire logic [mpa_pkg::NUM_PROC-1:0] dut_req_oe,
  input  wire logic                         core_prio_pull,
  input  wire logic                         dma_prio_pull,
  input  wire logic                         dut_core_prio_oe,
  input  wire logic                         dut_dma_prio_oe,
  input  wire logic                         dut_grant_oe,
  input  wire logic                         dut_grant_n,
  output logic      [mpa_pkg::NUM_PROC-1:0] req_lines,
  output logic                              core_prio_level,
  output logic                              dma_prio_level,
  output logic                              grant_level
);
  // Absent peers leave their lines to the pull-up, so they read high
  assign req_lines = ~(peer_pull | dut_req_oe);
  // Any party can pull the priority lines low
  assign core_prio_level = ~(core_prio_pull | dut_core_prio_oe);
  assign dma_prio_level  = ~(dma_prio_pull | dut_dma_prio_oe);
  // Grant wire floats to its pull-up unless the master drives it
  assign grant_level = dut_grant_oe ? dut_grant_n : 1'b1;
endmodule

// *** mpa_arbiter_tb.sv ***
// Self-checking bench for the arbiter with peers and a host.
// Assumes a 50 ns core clock; inputs change on the falling edge.
`timescale 1ns/1ps

module mpa_arbiter_tb;
  import mpa_pkg::*;
  logic core_clk = 1'b0, reset_n = 1'b0, ms_in = 1'b1, lk_in = 1'b0;
  logic backoff_n = 1'b1, hreq_n = 1'b1, core_prio_pull = 1'b0, dma_prio_pull = 1'b0;
  logic [ID_W-1:0] ident = 3'h0;
  logic [NUM_PROC-1:0] peer_pull = 8'h00, req_in, req_out, req_oe;
  logic grant_in, core_prio_in, dma_prio_in, mstr_n, mstr_oe, lk_n, lk_oe, grant_n, grant_oe;
  logic core_prio_out, core_prio_oe, dma_prio_out, dma_prio_oe;
  logic bus_oe, sref, granted, pre_bg, pre_np, restart;
  mpa_local_t lreq = '0;
  mpa_strap_t straps;
  int mismatches = 0, checks_done = 0;

  // Free-running core clock
  always #25 core_clk = ~core_clk;

  mpa_arbiter uut (.core_clk, .reset_n, .clk_en(1'b1), .processor_identity(ident),
    .arb_request_lines_in(req_in), .arb_request_lines_out(req_out),
    .arb_request_lines_oe(req_oe), .master_indicator_in(ms_in), .master_indicator_n(mstr_n),
    .master_indicator_oe(mstr_oe), .bus_locked_flag_in(lk_in), .bus_locked_flag_n(lk_n),
    .bus_locked_flag_oe(lk_oe), .backoff_input_n(backoff_n), .host_req_n(hreq_n),
    .host_grant_in(grant_in), .host_grant_n(grant_n), .host_grant_oe(grant_oe),
    .core_priority_line_in(core_prio_in), .core_priority_line_out(core_prio_out),
    .core_priority_line_oe(core_prio_oe), .dma_priority_line_in(dma_prio_in),
    .dma_priority_line_out(dma_prio_out), .dma_priority_line_oe(dma_prio_oe),
    .local_req(lreq),
    .bus_outputs_oe(bus_oe), .sdram_self_refresh(sref), .bus_granted(granted),
    .preempt_bg_dma(pre_bg), .preempt_np_dma(pre_np), .restart_xact(restart),
    .straps(straps));
  mpa_peer_model peers (.peer_pull, .dut_req_oe(req_oe), .core_prio_pull, .dma_prio_pull,
    .dut_core_prio_oe(core_prio_oe), .dut_dma_prio_oe(dma_prio_oe),
    .dut_grant_oe(grant_oe), .dut_grant_n(grant_n), .req_lines(req_in),
    .core_prio_level(core_prio_in), .dma_prio_level(dma_prio_in), .grant_level(grant_in));

  // One compare for every kind of result, counted
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Identity only changes while reset is held
  task automatic do_reset(input logic [ID_W-1:0] id);
    reset_n = 1'b0;
    ident = id;
    cyc(6);
    reset_n = 1'b1;
    cyc(3);
  endtask

  // Both strap levels are read while reset holds the pins floated
  task automatic t_straps;
    ms_in = 1'b0;
    lk_in = 1'b1;
    do_reset(3'h0);
    chk("straps", 8'h01, 8'(straps));
    chk("strap_oe", 8'h01, 8'(mstr_oe));
    ms_in = 1'b1;
    lk_in = 1'b0;
    do_reset(3'h0);
    chk("straps_swap", 8'h02, 8'(straps));
  endtask

  // Every identity wins an idle bus on its own line
  task automatic t_ident;
    for (int i = 0; i < NUM_PROC; i++)
    begin
      lreq = '0;
      do_reset(ID_W'(i));
      lreq.core_req = 1'b1;
      for (int k = 0; k < 20 && granted !== 1'b1; k++) cyc(1);
      chk("own_line", 8'h01 << i, req_oe);
      chk("master_n", 8'h00, 8'(mstr_n));
      chk("core_prio_oe", 8'h01, 8'(core_prio_oe));
    end
  endtask

  // A lower identity holding its line keeps us off the bus
  task automatic t_contend;
    lreq = '0;
    do_reset(3'h3);
    peer_pull = 8'h02;
    lreq.core_req = 1'b1;
    cyc(8);
    chk("blocked", 8'h00, 8'(granted));
    peer_pull = 8'h00;
    for (int k = 0; k < 20 && granted !== 1'b1; k++) cyc(1);
    chk("won", 8'h01, 8'(granted));
  endtask

  // Lock and priority lines while master with DMA traffic only
  task automatic t_prio;
    lreq = '0;
    lreq.bg_dma_req = 1'b1;
    lreq.np_dma_req = 1'b1;
    lreq.lock_req = 1'b1;
    lreq.hp_dma_req = 1'b1;
    cyc(5);
    chk("locked_n", 8'h00, 8'(lk_n));
    chk("dma_prio_oe", 8'h01, 8'(dma_prio_oe));
    chk("no_pre_bg", 8'h00, 8'(pre_bg));
    // Our own pull on the shared line must not preempt our own traffic
    chk("no_pre_np", 8'h00, 8'(pre_np));
    lreq.hp_dma_req = 1'b0;
    core_prio_pull = 1'b1;
    cyc(5);
    chk("pre_bg", 8'h01, 8'(pre_bg));
    core_prio_pull = 1'b0;
    dma_prio_pull = 1'b1;
    cyc(5);
    chk("pre_np", 8'h01, 8'(pre_np));
    dma_prio_pull = 1'b0;
  endtask

  // Host waits for the transaction, then owns the bus until it lets go
  task automatic t_host;
    lreq = '0;
    lreq.core_req = 1'b1;
    lreq.xact_busy = 1'b1;
    hreq_n = 1'b0;
    cyc(8);
    chk("early_grant", 8'h00, 8'(grant_oe));
    lreq.xact_busy = 1'b0;
    for (int k = 0; k < 20 && grant_in !== 1'b0; k++) cyc(1);
    chk("grant_n", 8'h00, 8'(grant_n));
    chk("self_ref", 8'h01, 8'(sref));
    chk("float", 8'h00, 8'(bus_oe));
    cyc(6);
    chk("grant_held", 8'h01, 8'(grant_oe));
    hreq_n = 1'b1;
    for (int k = 0; k < 20 && grant_oe !== 1'b0; k++) cyc(1);
    chk("grant_off", 8'h00, 8'(grant_oe));
  endtask

  // Back-off mid-transaction, then a restart on regaining the bus
  task automatic t_backoff;
    lreq = '0;
    do_reset(3'h0);
    lreq.core_req = 1'b1;
    lreq.xact_busy = 1'b1;
    for (int k = 0; k < 20 && granted !== 1'b1; k++) cyc(1);
    backoff_n = 1'b0;
    for (int k = 0; k < 8 && granted !== 1'b0; k++) cyc(1);
    chk("backed_off", 8'h00, 8'(granted));
    backoff_n = 1'b1;
    for (int k = 0; k < 20 && restart !== 1'b1; k++) cyc(1);
    chk("restart", 8'h01, 8'(restart));
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial
  begin
    #200_000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    cyc(1);
    t_straps();
    t_ident();
    t_contend();
    t_prio();
    t_host();
    t_backoff();
    end_of_test();
  end
endmodule
